// ==== hdl/flash_bus_cycle.sv ====
`timescale 1ns/1ns
`default_nettype none

// one read or write cycle on the flash pins, fixed length
module flash_bus_cycle #(
  parameter int LEN = flash_host_pkg::BUS_CYC
) (
  input  wire logic                              clk,
  input  wire logic                              reset_n,
  input  wire logic                              start,
  input  wire logic                              write,
  input  wire logic [flash_host_pkg::ADDR_W-1:0] addr,
  input  wire logic [flash_host_pkg::DATA_W-1:0] wdata,
  input  wire logic [flash_host_pkg::DATA_W-1:0] dq_i,
  output logic                                   done,
  output logic [flash_host_pkg::DATA_W-1:0]      rdata,
  output logic                                   ce_n,
  output logic                                   oe_n,
  output logic                                   we_n,
  output logic [flash_host_pkg::ADDR_W-1:0]      addr_o,
  output logic [flash_host_pkg::DATA_W-1:0]      dq_o,
  output logic                                   dq_oe
);

  logic [7:0] cnt_q;
  logic       busy_q;
  logic       wr_q;

  // =====================================================================
  // sequencing
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      busy_q <= 1'b0;
      cnt_q  <= 8'h00;
      wr_q   <= 1'b0;
      addr_o <= '0;
      dq_o   <= '0;
    end else if (start && !busy_q) begin
      busy_q <= 1'b1;
      cnt_q  <= 8'h00;
      wr_q   <= write;
      addr_o <= addr;
      dq_o   <= wdata;
    end else if (busy_q) begin
      cnt_q <= cnt_q + 8'h01;
      if (cnt_q == 8'(LEN - 1)) begin
        busy_q <= 1'b0;
      end
    end
  end

  // =====================================================================
  // strobes: address set up one clock before ce_n falls, two before oe_n/we_n; ce_n rises one clock after oe_n, two after we_n
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ce_n  <= 1'b1;
      oe_n  <= 1'b1;
      we_n  <= 1'b1;
      dq_oe <= 1'b0;
    end else begin
      ce_n  <= !(busy_q && cnt_q < 8'(LEN - 1));
      oe_n  <= !(busy_q && !wr_q && cnt_q >= 8'h01 && cnt_q < 8'(LEN - 2));
      we_n  <= !(busy_q && wr_q && cnt_q >= 8'h01 && cnt_q < 8'(LEN - 3));
      dq_oe <= busy_q && wr_q && cnt_q < 8'(LEN - 1);
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdata <= '0;
      done  <= 1'b0;
    end else begin
      done <= busy_q && cnt_q == 8'(LEN - 1);
      // sample while oe_n is still low
      if (busy_q && !wr_q && cnt_q == 8'(LEN - 3)) begin
        rdata <= dq_i;
      end
    end
  end

endmodule

`default_nettype wire

// ==== hdl/flash_host_ctrl.sv ====
`timescale 1ns/1ns
`default_nettype none

module flash_host_ctrl #(
  parameter int REC_BUSY_CYC = flash_host_pkg::REC_BUSY_CYC,
  parameter int POLL_LIMIT   = 65535,
  parameter bit USE_TOGGLE   = 1'b0
) (
  input  wire logic                              clk,
  input  wire logic                              reset_n,
  input  wire logic                              req_valid,
  output logic                                   req_ready,
  input  wire flash_host_pkg::req_s              req,
  output logic                                   rsp_valid,
  output flash_host_pkg::rsp_s                   rsp,
  output flash_host_pkg::pins_s                  pins,
  input  wire logic [flash_host_pkg::DATA_W-1:0] dq_i,
  input  wire logic                              ready_busy_out
);

  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_CMD     = 4'h1,
    ST_STATUS  = 4'h2,
    ST_CHECK   = 4'h3,
    ST_RST_LOW = 4'h4,
    ST_RST_REC = 4'h5,
    ST_UNPROT  = 4'h6,
    ST_READ    = 4'h7,
    ST_DONE    = 4'h8
  } state_e;

  state_e                              state_q;
  flash_host_pkg::req_s                req_q;
  logic [flash_host_pkg::CNT_W-1:0]    tcnt_q;
  logic [2:0]                          step_q;
  logic [2:0]                          nsteps;
  logic                                cyc_start;
  logic                                cyc_write;
  logic [flash_host_pkg::ADDR_W-1:0]   cyc_addr;
  logic [flash_host_pkg::DATA_W-1:0]   cyc_data;
  logic                                cyc_done;
  logic [flash_host_pkg::DATA_W-1:0]   cyc_rdata;
  logic                                prev_tog_q;
  logic                                have_prev_q;
  logic                                busy_op_q;
  logic                                ok_q;
  logic                                to_q;
  logic [flash_host_pkg::DATA_W-1:0]   rdata_q;
  logic                                unprot_q;
  logic                                rst_pin_q;

  // =====================================================================
  // command sequence table; the encodings are the common unlock set
  always_comb begin
    cyc_addr = 18'h00555;
    cyc_data = 16'h00aa;
    nsteps   = 3'h4;
    case (req_q.op)
      flash_host_pkg::OP_PROGRAM: begin
        case (step_q)
          3'h0: begin cyc_addr = 18'h00555; cyc_data = 16'h00aa; end
          3'h1: begin cyc_addr = 18'h002aa; cyc_data = 16'h0055; end
          3'h2: begin cyc_addr = 18'h00555; cyc_data = 16'h00a0; end
          default: begin cyc_addr = req_q.addr; cyc_data = req_q.data; end
        endcase
      end
      default: begin
        nsteps = 3'h6;
        case (step_q)
          3'h0, 3'h3: begin cyc_addr = 18'h00555; cyc_data = 16'h00aa; end
          3'h1, 3'h4: begin cyc_addr = 18'h002aa; cyc_data = 16'h0055; end
          3'h2: begin cyc_addr = 18'h00555; cyc_data = 16'h0080; end
          default: begin
            if (req_q.op == flash_host_pkg::OP_SECTOR_ERASE) begin
              // only the sector field of the address selects the sector
              cyc_addr = '0;
              cyc_addr[flash_host_pkg::SECTOR_HI_BIT:flash_host_pkg::SECTOR_LO_BIT] =
                req_q.addr[flash_host_pkg::SECTOR_HI_BIT:flash_host_pkg::SECTOR_LO_BIT];
              cyc_data = 16'h0030;
            end else begin
              cyc_addr = 18'h00555;
              cyc_data = 16'h0010;
            end
          end
        endcase
      end
    endcase
  end

  assign cyc_write = (state_q == ST_CMD);
  // no restart in the done cycle: step and state have not moved on yet, so a restart
  // there would repeat the old command word or read before the result is judged
  assign cyc_start = ((state_q == ST_CMD) || (state_q == ST_STATUS) || (state_q == ST_READ))
                     && !cyc_done;

  flash_bus_cycle u_cycle (
    .clk     (clk),
    .reset_n (reset_n),
    .start   (cyc_start),
    .write   (cyc_write),
    // status reads use the target address for polling; toggle reads use it too, harmless
    .addr    ((state_q == ST_CMD) ? cyc_addr : req_q.addr),
    .wdata   (cyc_data),
    .dq_i    (dq_i),
    .done    (cyc_done),
    .rdata   (cyc_rdata),
    .ce_n    (pins.ce_n),
    .oe_n    (pins.oe_n),
    .we_n    (pins.we_n),
    .addr_o  (pins.addr),
    .dq_o    (pins.dq_o),
    .dq_oe   (pins.dq_oe)
  );

  assign pins.reset_n      = rst_pin_q;
  assign pins.unprotect_hv = unprot_q;
  // new work only in idle, so a command overlaps a running algorithm only after a poll timeout
  assign req_ready = (state_q == ST_IDLE);

  // =====================================================================
  // main sequencer
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q     <= ST_IDLE;
      req_q       <= '0;
      step_q      <= 3'h0;
      tcnt_q      <= '0;
      prev_tog_q  <= 1'b0;
      have_prev_q <= 1'b0;
      busy_op_q   <= 1'b0;
      ok_q        <= 1'b0;
      to_q        <= 1'b0;
      rdata_q     <= '0;
      rst_pin_q   <= 1'b1;
      unprot_q    <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          step_q      <= 3'h0;
          tcnt_q      <= '0;
          have_prev_q <= 1'b0;
          if (req_valid) begin
            req_q <= req;
            ok_q  <= 1'b1;
            to_q  <= 1'b0;
            case (req.op)
              flash_host_pkg::OP_READ: state_q <= ST_READ;
              flash_host_pkg::OP_RESET: begin
                rst_pin_q <= 1'b0;
                state_q   <= ST_RST_LOW;
              end
              flash_host_pkg::OP_UNPROTECT: begin
                // each request flips the pin; taking it low again ends the unprotect window
                unprot_q <= !unprot_q;
                state_q  <= ST_UNPROT;
              end
              default: state_q <= ST_CMD;
            endcase
          end
        end
        ST_CMD: begin
          if (cyc_done) begin
            if (step_q == nsteps - 3'h1) begin
              busy_op_q <= 1'b1;
              state_q   <= ST_STATUS;
            end else begin
              step_q <= step_q + 3'h1;
            end
          end
        end
        ST_STATUS: begin
          if (cyc_done) begin
            state_q <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          state_q <= ST_STATUS;
          tcnt_q  <= tcnt_q + 1'b1;
          if (USE_TOGGLE) begin
            // a bit that stops flipping between two reads means done
            prev_tog_q  <= cyc_rdata[flash_host_pkg::TOGGLE_BIT];
            have_prev_q <= 1'b1;
            if (have_prev_q && prev_tog_q == cyc_rdata[flash_host_pkg::TOGGLE_BIT]) begin
              busy_op_q <= 1'b0;
              state_q   <= ST_DONE;
            end
          end else if (req_q.op == flash_host_pkg::OP_PROGRAM) begin
            if (cyc_rdata[flash_host_pkg::POLL_BIT] ==
                req_q.data[flash_host_pkg::POLL_BIT]) begin
              busy_op_q <= 1'b0;
              state_q   <= ST_DONE;
            end
          end else if (cyc_rdata[flash_host_pkg::POLL_BIT]) begin
            busy_op_q <= 1'b0;
            state_q   <= ST_DONE;
          end
          if (tcnt_q == flash_host_pkg::CNT_W'(POLL_LIMIT)) begin
            // gives up rather than hang; software may then pulse reset
            ok_q    <= 1'b0;
            to_q    <= 1'b1;
            state_q <= ST_DONE;
          end
        end
        ST_RST_LOW: begin
          tcnt_q <= tcnt_q + 1'b1;
          if (tcnt_q == flash_host_pkg::CNT_W'(flash_host_pkg::RESET_PULSE_CYC - 1)) begin
            rst_pin_q <= 1'b1;
            tcnt_q    <= '0;
            state_q   <= ST_RST_REC;
          end
        end
        ST_RST_REC: begin
          // the wait covers recovery from low and the high time before a read
          tcnt_q <= tcnt_q + 1'b1;
          if ((busy_op_q &&
               tcnt_q >= flash_host_pkg::CNT_W'(REC_BUSY_CYC)) ||
              (!busy_op_q && tcnt_q >= flash_host_pkg::CNT_W'(
                 flash_host_pkg::REC_IDLE_CYC + flash_host_pkg::RESET_HIGH_CYC))) begin
            busy_op_q <= 1'b0;
            state_q   <= ST_DONE;
          end
        end
        ST_UNPROT: begin
          tcnt_q <= tcnt_q + 1'b1;
          if (tcnt_q == flash_host_pkg::CNT_W'(flash_host_pkg::UNPROT_SETUP_CYC - 1)) begin
            state_q <= ST_DONE;
          end
        end
        ST_READ: begin
          if (cyc_done) begin
            rdata_q <= cyc_rdata;
            state_q <= ST_DONE;
          end
        end
        ST_DONE: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  assign rsp_valid    = (state_q == ST_DONE);
  assign rsp.ok       = ok_q;
  assign rsp.timeout  = to_q;
  assign rsp.data     = rdata_q;

endmodule

`default_nettype wire

// ==== hdl/flash_host_pkg.sv ====
`default_nettype none

package flash_host_pkg;

  // =====================================================================
  // bus widths
  localparam int ADDR_W = 18;
  localparam int DATA_W = 16;

  // =====================================================================
  // sector select field of the address (sector_select_low_bit..high_bit)
  localparam int SECTOR_LO_BIT = 12;
  localparam int SECTOR_HI_BIT = 17;
  localparam int SECTOR_W      = SECTOR_HI_BIT - SECTOR_LO_BIT + 1;

  // =====================================================================
  // status bit positions
  localparam int POLL_BIT   = 7;
  localparam int TOGGLE_BIT = 6;

  // =====================================================================
  // timing, as printed, and derived counts at 100 MHz
  localparam int CLK_PERIOD_NS           = 10;
  localparam int RESET_PULSE_MIN_NS      = 500;
  localparam int RESET_HIGH_BEFORE_RD_NS = 50;
  localparam int RESET_REC_BUSY_US       = 20;
  localparam int RESET_REC_IDLE_NS       = 500;
  localparam int RESET_SETUP_UNPROT_US   = 4;
  localparam int RESET_PULSE_CYC  = (RESET_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_HIGH_CYC   =
    (RESET_HIGH_BEFORE_RD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REC_BUSY_CYC     = (RESET_REC_BUSY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REC_IDLE_CYC     = (RESET_REC_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int UNPROT_SETUP_CYC =
    (RESET_SETUP_UNPROT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // one bus cycle on the flash pins lasts this many clocks
  localparam int BUS_CYC          = 10;
  localparam int CNT_W            = 16;

  // =====================================================================
  // operations the user side may ask for
  typedef enum logic [2:0] {
    OP_READ        = 3'h0,
    OP_PROGRAM     = 3'h1,
    OP_CHIP_ERASE  = 3'h2,
    OP_SECTOR_ERASE = 3'h3,
    OP_RESET       = 3'h4,
    OP_UNPROTECT   = 3'h5
  } op_e;

  typedef struct packed {
    op_e                op;
    logic [ADDR_W-1:0]  addr;
    logic [DATA_W-1:0]  data;
  } req_s;

  typedef struct packed {
    logic               ok;
    logic               timeout;
    logic [DATA_W-1:0]  data;
  } rsp_s;

  // pins toward the flash
  typedef struct packed {
    logic              ce_n;
    logic              oe_n;
    logic              we_n;
    logic              reset_n;
    logic              unprotect_hv;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_o;
    logic              dq_oe;
  } pins_s;

endpackage

`default_nettype wire

// ==== sim/flash_dev_model.sv ====
`timescale 1ns/1ns
`default_nettype none

module flash_dev_model (
  input  wire logic                  clk,
  input  wire flash_host_pkg::pins_s pins,
  input  wire logic [16:0]           busy_len,
  output logic [15:0]                dq_i,
  output logic                       ready_busy_out
);
  logic [15:0] mem [0:262143];
  logic [15:0] pdata = 16'h0000;
  logic [17:0] paddr = 18'h00000;
  logic [7:0]  last_cmd = 8'h00;
  logic        we_q = 1'b1;
  logic        oe_q = 1'b1;
  logic        tog_q = 1'b0;
  logic        prog_q = 1'b0;
  int          busy_cnt = 0;

  initial begin
    dq_i = 16'h0000;
    for (int i = 0; i < 262144; i++) mem[i] = 16'hffff;
  end
  assign ready_busy_out = (busy_cnt == 0);

  // status word ignores the address while busy
  function automatic logic [15:0] rd_word();
    if (busy_cnt != 0) return {8'h00, prog_q ? ~pdata[7] : 1'b0, tog_q, 6'h00};
    return mem[pins.addr];
  endfunction

  // ======================================================
  // unselected bus shows a changing pattern: the last word and its inverse in turn
  always @(posedge clk) begin
    we_q <= pins.we_n;
    oe_q <= pins.oe_n;
    dq_i <= (!pins.ce_n && !pins.oe_n) ? rd_word() : ~dq_i;
    if (oe_q && !pins.oe_n && !pins.ce_n) tog_q <= ~tog_q;
    if (!pins.reset_n) begin
      busy_cnt <= 0;
      last_cmd <= 8'h00;
    end else if (busy_cnt > 0) begin
      busy_cnt <= busy_cnt - 1;
      if (busy_cnt == 1 && prog_q) mem[paddr] = mem[paddr] & pdata;
    end else if (we_q && !pins.we_n && !pins.ce_n) begin
      last_cmd <= pins.dq_o[7:0];
      if (last_cmd == 8'ha0) begin
        paddr <= pins.addr;
        pdata <= pins.dq_o;
        prog_q <= 1'b1;
        busy_cnt <= int'(busy_len);
        last_cmd <= 8'h00;
      end else if (pins.dq_o[7:0] == 8'h10) begin
        for (int i = 0; i < 262144; i++) mem[i] = 16'hffff;
        prog_q <= 1'b0;
        busy_cnt <= int'(busy_len);
      end else if (pins.dq_o[7:0] == 8'h30) begin
        for (int i = 0; i < 4096; i++) mem[{pins.addr[17:12], i[11:0]}] = 16'hffff;
        prog_q <= 1'b0;
        busy_cnt <= int'(busy_len);
      end
    end
  end
endmodule

`default_nettype wire

// ==== sim/flash_host_ctrl_assertions.sv ====
`timescale 1ns/1ns
`default_nettype none

module flash_host_ctrl_assertions (
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire logic                  req_valid,
  input  wire logic                  req_ready,
  input  wire flash_host_pkg::req_s  req,
  input  wire logic                  rsp_valid,
  input  wire flash_host_pkg::pins_s pins
);
  logic [9:0]  lo_cnt_q;
  logic [9:0]  hv_cnt_q;
  logic [11:0] fall_cnt_q;
  logic        pin_q;
  logic        prog_q;
  logic [17:0] addr_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // ======================================================
  // helper counters, saturating so long idle spells stay legal
  always_ff @(posedge clk) begin
    if (!reset_n || pins.reset_n) lo_cnt_q <= 10'h000;
    else if (lo_cnt_q != 10'h3ff) lo_cnt_q <= lo_cnt_q + 10'h001;
  end
  always_ff @(posedge clk) begin
    if (!reset_n || !pins.unprotect_hv) hv_cnt_q <= 10'h000;
    else if (hv_cnt_q != 10'h3ff) hv_cnt_q <= hv_cnt_q + 10'h001;
  end
  always_ff @(posedge clk) begin
    pin_q <= pins.reset_n;
    if (!reset_n) fall_cnt_q <= 12'hfff;
    else if (pin_q && !pins.reset_n) fall_cnt_q <= 12'h001;
    else if (fall_cnt_q != 12'hfff) fall_cnt_q <= fall_cnt_q + 12'h001;
  end
  always_ff @(posedge clk) begin
    if (!reset_n || rsp_valid) prog_q <= 1'b0;
    else if (req_valid && req_ready) prog_q <= (req.op == flash_host_pkg::OP_PROGRAM);
    if (req_valid && req_ready) addr_q <= req.addr;
  end

  // ======================================================
  // properties
  chk_reset_pulse_len: assert property (
    $rose(pins.reset_n) |-> lo_cnt_q >= flash_host_pkg::RESET_PULSE_CYC)
    else $error("reset pin pulse shorter than minimum");
  chk_read_after_rst: assert property (
    $rose(pins.reset_n) |-> pins.oe_n [*5])
    else $error("read started too soon after reset release");
  chk_unprot_setup: assert property (
    $fell(pins.we_n) && pins.unprotect_hv |-> hv_cnt_q >= flash_host_pkg::UNPROT_SETUP_CYC)
    else $error("write too soon after unprotect voltage");
  chk_taken_busy: assert property (
    req_valid && req_ready |=> !req_ready)
    else $error("new request accepted while busy");
  chk_idle_quiet: assert property (
    req_ready |-> pins.ce_n && pins.we_n && pins.oe_n && !pins.dq_oe)
    else $error("bus active while idle");
  chk_rsp_pulse_one: assert property (
    rsp_valid |=> !rsp_valid)
    else $error("answer longer than one cycle");
  chk_poll_target_addr: assert property (
    $fell(pins.oe_n) && prog_q |-> pins.addr == addr_q)
    else $error("status read off the target address");
  chk_reset_recovery: assert property (
    $fell(pins.ce_n) |-> fall_cnt_q >= flash_host_pkg::REC_IDLE_CYC)
    else $error("access before reset recovery");
endmodule

bind flash_host_ctrl flash_host_ctrl_assertions flash_host_ctrl_assertions_inst (
  .clk       (clk),
  .reset_n   (reset_n),
  .req_valid (req_valid),
  .req_ready (req_ready),
  .req       (req),
  .rsp_valid (rsp_valid),
  .pins      (pins)
);

`default_nettype wire

// ==== sim/flash_host_ctrl_test.sv ====
`timescale 1ns/1ns
`default_nettype none

module flash_host_ctrl_test;
  logic                              clk = 1'b0;
  logic                              reset_n = 1'b0;
  logic                              req_valid = 1'b0;
  logic                              req_ready;
  flash_host_pkg::req_s              req = '0;
  logic                              rsp_valid;
  flash_host_pkg::rsp_s              rsp;
  flash_host_pkg::pins_s             pins;
  logic [flash_host_pkg::DATA_W-1:0] dq_i;
  logic                              ready_busy_out;
  logic [16:0]                       busy_len = 17'h0001e;
  int                                error_cnt = 0;
  int                                total_checks = 0;
  flash_host_pkg::rsp_s              r;
  logic                              tg_valid = 1'b0;
  logic                              tg_ready;
  flash_host_pkg::req_s              tg_req = '0;
  logic                              tg_rsp_valid;
  flash_host_pkg::rsp_s              tg_rsp;
  flash_host_pkg::pins_s             tg_pins;
  logic [flash_host_pkg::DATA_W-1:0] tg_dq;
  logic                              tg_rb;

  always #5 clk = ~clk;

  flash_host_ctrl #(.REC_BUSY_CYC(20), .POLL_LIMIT(50), .USE_TOGGLE(1'b0))
    flash_host_ctrl_inst (
    .clk(clk), .reset_n(reset_n), .req_valid(req_valid), .req_ready(req_ready), .req(req),
    .rsp_valid(rsp_valid), .rsp(rsp), .pins(pins), .dq_i(dq_i), .ready_busy_out(ready_busy_out));
  flash_dev_model flash_dev_model_inst (
    .clk(clk), .pins(pins), .busy_len(busy_len), .dq_i(dq_i), .ready_busy_out(ready_busy_out));
  // second controller in toggle-bit mode with its own device, so both completion checks run
  flash_host_ctrl #(.REC_BUSY_CYC(20), .POLL_LIMIT(50), .USE_TOGGLE(1'b1))
    flash_host_ctrl_tog_inst (
    .clk(clk), .reset_n(reset_n), .req_valid(tg_valid), .req_ready(tg_ready), .req(tg_req),
    .rsp_valid(tg_rsp_valid), .rsp(tg_rsp), .pins(tg_pins), .dq_i(tg_dq), .ready_busy_out(tg_rb));
  flash_dev_model flash_dev_model_tog_inst (
    .clk(clk), .pins(tg_pins), .busy_len(busy_len), .dq_i(tg_dq), .ready_busy_out(tg_rb));

  // ======================================================
  // shared tasks
  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic give_up(input string msg);
    error_cnt++;
    $display("wrong value at %0t: %s", $time, msg);
    report_and_stop();
  endtask
  // request held until the edge that takes it; answer caught in its single cycle
  task automatic do_op(input flash_host_pkg::op_e op, input logic [17:0] a, input logic [15:0] d,
                       input bit tog = 1'b0);
    int n;
    if (tog) begin
      tg_req   = '{op: op, addr: a, data: d};
      tg_valid = 1'b1;
    end else begin
      req       = '{op: op, addr: a, data: d};
      req_valid = 1'b1;
    end
    for (n = 0; n < 20000 && (tog ? tg_ready : req_ready) !== 1'b1; n++) @(posedge clk) #1;
    if (n == 20000) give_up("request never taken");
    @(posedge clk) #1;
    req_valid = 1'b0;
    tg_valid  = 1'b0;
    for (n = 0; n < 20000 && (tog ? tg_rsp_valid : rsp_valid) !== 1'b1; n++) @(posedge clk) #1;
    if (n == 20000) give_up("no answer");
    r = tog ? tg_rsp : rsp;
    @(posedge clk) #1;
  endtask

  // ======================================================
  // scenarios
  task automatic t_program(input logic [17:0] a, input logic [15:0] d);
    do_op(flash_host_pkg::OP_PROGRAM, a, d);
    check(r.ok === 1'b1 && r.timeout === 1'b0, "program status");
    do_op(flash_host_pkg::OP_READ, a, 16'h0000);
    check(r.data === d, "program readback");
  endtask
  task automatic t_erase();
    t_program(18'h20010, 16'h1111);
    do_op(flash_host_pkg::OP_SECTOR_ERASE, 18'h01000, 16'h0000);
    check(r.ok === 1'b1, "sector erase status");
    do_op(flash_host_pkg::OP_READ, 18'h01234, 16'h0000);
    check(r.data === 16'hffff, "sector word kept");
    do_op(flash_host_pkg::OP_READ, 18'h20010, 16'h0000);
    check(r.data === 16'h1111, "other sector lost");
    do_op(flash_host_pkg::OP_CHIP_ERASE, 18'h00000, 16'h0000);
    check(r.ok === 1'b1, "chip erase status");
    do_op(flash_host_pkg::OP_READ, 18'h20010, 16'h0000);
    check(r.data === 16'hffff, "chip word kept");
  endtask
  task automatic t_unprotect();
    do_op(flash_host_pkg::OP_UNPROTECT, 18'h00000, 16'h0000);
    check(pins.unprotect_hv === 1'b1, "unprotect voltage off");
    t_program(18'h00100, 16'h00a5);
    do_op(flash_host_pkg::OP_UNPROTECT, 18'h00000, 16'h0000);
    check(pins.unprotect_hv === 1'b0, "unprotect voltage stuck");
  endtask
  task automatic t_toggle();
    do_op(flash_host_pkg::OP_PROGRAM, 18'h00345, 16'h0f0f, 1'b1);
    check(r.ok === 1'b1 && r.timeout === 1'b0 && tg_rb === 1'b1, "toggle done early");
    do_op(flash_host_pkg::OP_READ, 18'h00345, 16'h0000, 1'b1);
    check(r.data === 16'h0f0f, "toggle program readback");
  endtask
  task automatic t_abort();
    busy_len = 17'h1ffff;
    do_op(flash_host_pkg::OP_PROGRAM, 18'h00077, 16'h0000);
    check(r.timeout === 1'b1 && r.ok === 1'b0, "stuck program not flagged");
    do_op(flash_host_pkg::OP_RESET, 18'h00000, 16'h0000);
    check(r.ok === 1'b1 && ready_busy_out === 1'b1, "reset left device busy");
    busy_len = 17'h0001e;
    do_op(flash_host_pkg::OP_READ, 18'h00077, 16'h0000);
    check(r.data === 16'hffff, "aborted word written");
  endtask

  initial begin
    repeat (2) @(posedge clk);
    #1 reset_n = 1'b1;
    check(req_ready === 1'b1 && rsp_valid === 1'b0 && pins.reset_n === 1'b1 &&
          pins.dq_oe === 1'b0, "idle after reset");
    t_program(18'h01234, 16'h5a3c);
    busy_len = 17'h00064;
    t_program(18'h01235, 16'h00c3);
    busy_len = 17'h0001e;
    t_erase();
    do_op(flash_host_pkg::OP_RESET, 18'h00000, 16'h0000);
    check(r.ok === 1'b1 && pins.reset_n === 1'b1, "idle reset");
    t_unprotect();
    t_toggle();
    t_abort();
    report_and_stop();
  end
endmodule

`default_nettype wire
